// ===== core/uot_core.sv
// otg core: reset, interrupts, fifo window, host port and scheduling
`timescale 1ns/1ps
// Behaviour
// - stop output stays asserted while the core is in reset
// - reset clears interface, scheduler, queues and all status state
// - reset synchronised into bus clock and separately into ulpi clock
// - core soft reset input resets the controller
// - host interrupt sources include wakeup, disconnect, channel, port
// - periodic tx empty interrupt can fire at half empty
// - device interrupt sources feed the single interrupt output
// - device flags iso out drop when rx space below max packet
// - common sources: id change, mode mismatch, fifo levels, sof
// - otg sources: debounce, timeout, hnp, srp, session end
// - fifo window writes beyond 32 KB are ignored
// - port power drives bus supply enable, then waits for connect
// - device connect sets the connect detected bit and interrupts
// - reset release sets enable change and speed, failed hs is fs
// - two request queues keep token and channel, each issued in its own write order
// - periodic queue served before nonperiodic at each frame start
// - channels rotate round robin; completion writes descriptor back
// - rx status entry carries channel, byte count and validity
// - access to the other mode's registers raises mode mismatch
module uot_core
  import uot_pkg::*;
#(
  parameter int unsigned NCH  = 8,
  parameter int unsigned QD   = 8,
  parameter int unsigned PTXD = 256
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             ulpi_clk_i,
  input  wire logic             soft_reset_i,
  input  wire logic             host_mode_i,
  input  wire logic             ulpi_conn_i,
  input  wire logic             ulpi_hs_i,
  output logic                  ulpi_stp_o,
  input  wire uot_irq_t         evt_i,
  input  wire uot_irq_t         int_mask_i,
  input  wire uot_irq_t         int_clr_i,
  output uot_irq_t              int_sts_o,
  output logic                  irq_o,
  input  wire logic             ptx_half_i,
  input  wire logic [8:0]       ptx_lvl_i,
  input  wire logic             iso_out_i,
  input  wire logic [12:0]      rx_free_i,
  input  wire logic [12:0]      iso_mps_i,
  input  wire logic             reg_acc_i,
  input  wire logic [1:0]       reg_grp_i,
  input  wire logic             fifo_wr_i,
  input  wire logic             fifo_rd_i,
  input  wire logic [16:0]      fifo_addr_i,
  input  wire logic [31:0]      fifo_wdata_i,
  output logic                  spram_we_o,
  output logic                  spram_re_o,
  output logic [SAW-1:0]        spram_addr_o,
  output logic [31:0]           spram_wdata_o,
  input  wire logic             port_power_i,
  input  wire logic             port_reset_i,
  input  wire logic             conn_clr_i,
  input  wire logic             enchg_clr_i,
  output logic                  vbus_en_o,
  output logic                  port_conn_det_o,
  output logic                  port_en_chg_o,
  output logic                  port_enabled_o,
  output logic [1:0]            port_speed_o,
  input  wire logic             pq_wr_i,
  input  wire logic             nq_wr_i,
  input  wire uot_req_t         req_i,
  input  wire logic             sof_i,
  input  wire logic             txn_done_i,
  output logic                  txn_valid_o,
  output uot_txn_t              txn_o,
  input  wire logic [NCH-1:0]   chan_en_i,
  output logic [CHW-1:0]        rr_chan_o,
  input  wire logic             chan_done_i,
  input  wire logic [CHW-1:0]   chan_done_id_i,
  output logic                  desc_wb_o,
  output logic [CHW-1:0]        desc_wb_chan_o,
  input  wire logic             rx_pkt_i,
  input  wire uot_rxsts_t       rx_sts_i,
  output logic                  rxsts_vld_o,
  output uot_rxsts_t            rxsts_o
);

  localparam int unsigned QAW = $clog2(QD);
  localparam logic [QAW:0] QFULL = (QAW+1)'(QD);
  localparam logic [8:0] PTX_HALF = 9'(PTXD / 2);

  typedef struct packed {
    uot_req_t [QD-1:0] pq_mem;
    uot_req_t [QD-1:0] nq_mem;
    logic [QAW-1:0]    pq_wp;
    logic [QAW-1:0]    pq_rp;
    logic [QAW-1:0]    nq_wp;
    logic [QAW-1:0]    nq_rp;
    logic [QAW:0]      pq_cnt;
    logic [QAW:0]      nq_cnt;
    logic              per_phase;
    logic              busy;
    uot_txn_t          txn;
    logic [CHW-1:0]    rr;
    logic              wb;
    logic [CHW-1:0]    wb_chan;
    uot_rxsts_t        rxs;
    logic              rxs_vld;
    uot_port_e         pst;
    logic              vbus;
    logic              conn_det;
    logic              en_chg;
    logic              port_en;
    logic [1:0]        spd;
    logic              conn_prev;
    logic [IRQW-1:0]   sts;
    logic              irq;
    logic              spram_we;
    logic              spram_re;
    logic [SAW-1:0]    spram_addr;
    logic [31:0]       spram_wd;
  } uot_cst_t;

  typedef struct packed {
    logic stp;
    logic conn;
    logic hs;
  } uot_lst_t;

  uot_cst_t        q;
  uot_cst_t        d;
  uot_lst_t        lq;
  uot_lst_t        ld;
  logic [3:0]      lsync;
  logic [2:0]      msync;
  logic            core_rst;
  logic            conn_m;
  logic            hs_m;
  logic            rst_u;
  uot_irq_t        ev;
  logic [IRQW-1:0] raw;
  logic            pq_push;
  logic            nq_push;
  logic            pq_pop;
  logic            nq_pop;
  logic            conn_rise;

  // link side: reset, soft reset and pins enter the ulpi clock
  uot_sync2 #(.W(4)) u_lsync (
    .clk_i (ulpi_clk_i),
    .d_i   ({reset_i, soft_reset_i, ulpi_conn_i, ulpi_hs_i}),
    .q_o   (lsync)
  );

  // bus side: reset and the registered link levels enter mclk
  uot_sync2 #(.W(3)) u_msync (
    .clk_i (mclk_i),
    .d_i   ({reset_i, lq.conn, lq.hs}),
    .q_o   (msync)
  );

  assign rst_u    = lsync[3] | lsync[2];
  assign core_rst = msync[2] | soft_reset_i;
  assign conn_m   = msync[1];
  assign hs_m     = msync[0];

  always_comb begin
    ld      = lq;
    ld.stp  = rst_u;
    ld.conn = rst_u ? 1'b0 : lsync[1];
    ld.hs   = rst_u ? 1'b0 : lsync[0];
  end

  always_ff @(posedge ulpi_clk_i) begin
    lq <= ld;
  end

  always_comb begin
    int idx;
    idx = 0;
    d   = q;
    d.wb      = 1'b0;
    d.rxs_vld = 1'b0;
    d.spram_we = 1'b0;
    d.spram_re = 1'b0;

    // request queues, each issued in its own write order, periodic queue first
    pq_push = pq_wr_i && (q.pq_cnt != QFULL);
    nq_push = nq_wr_i && (q.nq_cnt != QFULL);
    pq_pop  = !q.busy && (q.pq_cnt != '0);
    nq_pop  = !q.busy && (q.pq_cnt == '0) && (q.nq_cnt != '0)
              && !q.per_phase;
    if (txn_done_i) begin
      d.busy = 1'b0;
    end
    if (!q.busy && (q.pq_cnt == '0)) begin
      d.per_phase = 1'b0;
    end
    if (sof_i) begin
      d.per_phase = 1'b1;
    end
    if (pq_pop) begin
      d.txn.periodic = 1'b1;
      d.txn.req      = q.pq_mem[q.pq_rp];
      d.busy         = 1'b1;
      d.pq_rp        = q.pq_rp + 1'b1;
    end else if (nq_pop) begin
      d.txn.periodic = 1'b0;
      d.txn.req      = q.nq_mem[q.nq_rp];
      d.busy         = 1'b1;
      d.nq_rp        = q.nq_rp + 1'b1;
    end
    if (pq_push) begin
      d.pq_mem[q.pq_wp] = req_i;
      d.pq_wp           = q.pq_wp + 1'b1;
    end
    if (nq_push) begin
      d.nq_mem[q.nq_wp] = req_i;
      d.nq_wp           = q.nq_wp + 1'b1;
    end
    d.pq_cnt = q.pq_cnt + {{QAW{1'b0}}, pq_push}
                        - {{QAW{1'b0}}, pq_pop};
    d.nq_cnt = q.nq_cnt + {{QAW{1'b0}}, nq_push}
                        - {{QAW{1'b0}}, nq_pop};

    // round robin over enabled channels, nearest one wins
    if (txn_done_i) begin
      for (int i = NCH; i >= 1; i--) begin
        idx = (int'(q.rr) + i) % NCH;
        if (chan_en_i[idx]) begin
          d.rr = CHW'(idx);
        end
      end
    end
    if (chan_done_i) begin
      d.wb      = 1'b1;
      d.wb_chan = chan_done_id_i;
    end

    if (rx_pkt_i) begin
      d.rxs     = rx_sts_i;
      d.rxs_vld = 1'b1;
    end

    // fifo window
    if (fifo_wr_i || fifo_rd_i) begin
      d.spram_addr = fifo_addr_i[SAW+1:2];
      d.spram_wd   = fifo_wdata_i;
    end
    d.spram_we = fifo_wr_i && (fifo_addr_i < SPRAM_LIM);
    d.spram_re = fifo_rd_i;

    // host port; clears first so a same-cycle set wins
    ev = evt_i;
    ev.h_disc = 1'b0;
    ev.h_port = 1'b0;
    if (conn_clr_i) begin
      d.conn_det = 1'b0;
    end
    if (enchg_clr_i) begin
      d.en_chg = 1'b0;
    end
    conn_rise   = conn_m && !q.conn_prev;
    d.conn_prev = conn_m;
    d.vbus      = port_power_i;
    unique case (q.pst)
      P_OFF: begin
        if (port_power_i) begin
          d.pst = P_WAIT;
        end
      end
      P_WAIT: begin
        if (conn_rise) begin
          d.conn_det = 1'b1;
          ev.h_port  = 1'b1;
          d.pst      = P_CONN;
        end
      end
      P_CONN: begin
        if (port_reset_i) begin
          d.pst = P_RST;
        end
      end
      P_RST: begin
        if (!port_reset_i) begin
          d.pst     = P_EN;
          d.en_chg  = 1'b1;
          d.port_en = 1'b1;
          d.spd     = hs_m ? SPD_HS : SPD_FS;
          ev.h_port = 1'b1;
        end
      end
      P_EN: begin
      end
      default: begin
        d.pst = P_OFF;
      end
    endcase
    if ((q.pst != P_OFF) && (q.pst != P_WAIT) && !conn_m) begin
      d.pst     = P_WAIT;
      d.port_en = 1'b0;
      ev.h_disc = 1'b1;
      if (q.port_en) begin
        d.en_chg  = 1'b1;
        ev.h_port = 1'b1;
      end
    end
    if (!port_power_i) begin
      d.pst     = P_OFF;
      d.port_en = 1'b0;
    end

    // interrupt sources raised inside the core
    ev.h_ptx_emp  = ptx_half_i ? (ptx_lvl_i <= PTX_HALF)
                               : (ptx_lvl_i == 9'h000);
    ev.c_mode_mis = reg_acc_i &&
                    ((host_mode_i && (reg_grp_i == GRP_DEV)) ||
                     (!host_mode_i && (reg_grp_i == GRP_HOST)));
    ev.d_iso_fail = iso_out_i && (rx_free_i < iso_mps_i);
    ev.c_sof      = evt_i.c_sof | sof_i;
    raw = ev;
    if (host_mode_i) begin
      raw = raw & ~DEV_MASK;
    end else begin
      raw = raw & ~HOST_MASK;
    end
    // sticky flags: new event beats a clear in the same cycle
    d.sts = (q.sts & ~int_clr_i) | raw;
    d.irq = |(d.sts & int_mask_i);

    if (core_rst) begin
      d = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    q <= d;
  end

  assign ulpi_stp_o      = lq.stp;
  assign int_sts_o       = q.sts;
  assign irq_o           = q.irq;
  assign spram_we_o      = q.spram_we;
  assign spram_re_o      = q.spram_re;
  assign spram_addr_o    = q.spram_addr;
  assign spram_wdata_o   = q.spram_wd;
  assign vbus_en_o       = q.vbus;
  assign port_conn_det_o = q.conn_det;
  assign port_en_chg_o   = q.en_chg;
  assign port_enabled_o  = q.port_en;
  assign port_speed_o    = q.spd;
  assign txn_valid_o     = q.busy;
  assign txn_o           = q.txn;
  assign rr_chan_o       = q.rr;
  assign desc_wb_o       = q.wb;
  assign desc_wb_chan_o  = q.wb_chan;
  assign rxsts_vld_o     = q.rxs_vld;
  assign rxsts_o         = q.rxs;

  sequence s_rst_release;
    (q.pst == P_RST) && !port_reset_i && port_power_i && conn_m;
  endsequence

  sequence s_enabled(logic hs);
    port_en_chg_o && port_enabled_o &&
    (port_speed_o == (hs ? SPD_HS : SPD_FS));
  endsequence

  chk_stp_in_reset: assert property (
    @(posedge ulpi_clk_i) lsync[3] |=> ulpi_stp_o)
    else $error("stop output not held during reset");

  chk_irq_pending: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    (|(q.sts & int_mask_i)) |-> irq_o)
    else $error("interrupt low while enabled flag pends");

  chk_vbus_power: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    port_power_i ##1 port_power_i |=> vbus_en_o && q.pst != P_OFF)
    else $error("supply enable missing after port power");

  chk_conn_detect: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    (q.pst == P_WAIT) && conn_rise && port_power_i
    |=> port_conn_det_o ##1 int_sts_o.h_port || !host_mode_i)
    else $error("connect not flagged");

  chk_port_enable: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    s_rst_release |=> s_enabled($past(hs_m)))
    else $error("port enable or speed wrong after reset");

  chk_window_write: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    fifo_wr_i |=> spram_we_o == ($past(fifo_addr_i) < SPRAM_LIM))
    else $error("fifo window write gating wrong");

  chk_periodic_first: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    !txn_valid_o && (q.pq_cnt != '0) |=> txn_valid_o && txn_o.periodic)
    else $error("nonperiodic issued ahead of periodic");

  chk_mode_mismatch: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    reg_acc_i && host_mode_i && (reg_grp_i == GRP_DEV)
    |=> int_sts_o.c_mode_mis)
    else $error("mode mismatch not flagged");

  chk_soft_reset: assert property (
    @(posedge mclk_i) soft_reset_i
    |=> !txn_valid_o && !irq_o && (int_sts_o == '0))
    else $error("soft reset did not clear core state");

  chk_desc_wb: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    chan_done_i |=> desc_wb_o && desc_wb_chan_o == $past(chan_done_id_i)
    ##1 !desc_wb_o || $past(chan_done_i))
    else $error("descriptor write back missing");

  chk_iso_fail: assert property (
    @(posedge mclk_i) disable iff (core_rst)
    iso_out_i && !host_mode_i && (rx_free_i < iso_mps_i)
    |=> int_sts_o.d_iso_fail)
    else $error("iso out drop not flagged");

endmodule : uot_core

// ===== core/uot_pkg.sv
// package: shared types and constants of the otg link logic core
package uot_pkg;

  localparam int unsigned CHW  = 4;
  localparam int unsigned IRQW = 27;
  localparam int unsigned SAW  = 13;

  // direct fifo window: 32 KB of byte address space
  localparam logic [16:0] SPRAM_LIM = 17'h08000;

  // interrupt field groups, host fields on top
  localparam logic [IRQW-1:0] HOST_MASK = 27'h7f00000;
  localparam logic [IRQW-1:0] DEV_MASK  = 27'h00ffc00;

  localparam logic [1:0] SPD_HS = 2'h0;
  localparam logic [1:0] SPD_FS = 2'h1;

  localparam logic [1:0] GRP_GLOB = 2'h0;
  localparam logic [1:0] GRP_HOST = 2'h1;
  localparam logic [1:0] GRP_DEV  = 2'h2;

  typedef enum logic [1:0] {
    TOK_SETUP = 2'h0,
    TOK_IN    = 2'h1,
    TOK_OUT   = 2'h2
  } uot_tok_e;

  typedef enum logic [2:0] {
    P_OFF  = 3'h0,
    P_WAIT = 3'h1,
    P_CONN = 3'h2,
    P_RST  = 3'h3,
    P_EN   = 3'h4
  } uot_port_e;

  typedef struct packed {
    uot_tok_e       tok;
    logic [CHW-1:0] chan;
  } uot_req_t;

  typedef struct packed {
    logic     periodic;
    uot_req_t req;
  } uot_txn_t;

  typedef struct packed {
    logic [CHW-1:0] chan;
    logic [10:0]    bcnt;
    logic           valid;
  } uot_rxsts_t;

  typedef struct packed {
    logic h_rwake, h_sreq, h_disc, h_ptx_emp, h_chan, h_incomp, h_port;
    logic d_resume, d_usbrst, d_susp, d_fetch, d_iso_out, d_iso_in;
    logic d_ep_pend, d_eopf, d_iso_fail, d_enum;
    logic c_conn_id, c_mode_mis, c_nptx_emp, c_rx_lvl, c_sof;
    logic o_debounce, o_a_tmout, o_hnp_done, o_srp_done, o_sess_end;
  } uot_irq_t;

endpackage : uot_pkg

// ===== core/uot_sync2.sv
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module uot_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } uot_sync_t;

  uot_sync_t s_d;
  uot_sync_t s_q;

  always_comb begin
    s_d      = s_q;
    s_d.meta = d_i;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign q_o = s_q.stab;

endmodule : uot_sync2

// ===== tb/uot_phy_model.sv
// link-side phy model: free-running link clock, attach and speed levels
`timescale 1ns/1ps
module uot_phy_model (
  input  wire logic ulpi_stp_i,
  input  wire logic attach_i,
  input  wire logic hs_cap_i,
  output logic      ulpi_clk_o,
  output logic      conn_o,
  output logic      hs_o,
  output int        stp_cnt_o
);
  // 48 ns period, offset so its edges drift against the bus clock
  initial begin
    ulpi_clk_o = 1'b0;
    #7;
    forever #24 ulpi_clk_o = ~ulpi_clk_o;
  end

  initial begin
    conn_o    = 1'b0;
    hs_o      = 1'b0;
    stp_cnt_o = 0;
  end

  // line levels change away from the edge the core samples on
  always @(negedge ulpi_clk_o) begin
    conn_o <= attach_i;
    hs_o   <= attach_i & hs_cap_i;
  end

  // counts link clocks supplied while stop is held
  always @(posedge ulpi_clk_o) begin
    stp_cnt_o <= ulpi_stp_i ? stp_cnt_o + 1 : 0;
  end
endmodule : uot_phy_model

// ===== tb/testbench.sv
// self-checking bench for the otg core with a link-side phy model
`timescale 1ns/1ps
module testbench;
  import uot_pkg::*;
  logic mclk_i, reset_i, soft_reset_i, host_mode_i, ulpi_conn_i, ulpi_hs_i;
  logic ulpi_clk_i, ulpi_stp_o, irq_o, ptx_half_i, iso_out_i, reg_acc_i;
  logic fifo_wr_i, fifo_rd_i, spram_we_o, spram_re_o, port_power_i;
  logic port_reset_i, conn_clr_i, enchg_clr_i, vbus_en_o, port_conn_det_o;
  logic port_en_chg_o, port_enabled_o, pq_wr_i, nq_wr_i, sof_i, txn_done_i;
  logic txn_valid_o, chan_done_i, desc_wb_o, rx_pkt_i, rxsts_vld_o;
  logic       [1:0]     reg_grp_i, port_speed_o;
  logic       [8:0]     ptx_lvl_i;
  logic       [12:0]    rx_free_i, iso_mps_i;
  logic       [16:0]    fifo_addr_i;
  logic       [SAW-1:0] spram_addr_o;
  logic       [31:0]    fifo_wdata_i, spram_wdata_o;
  logic       [7:0]     chan_en_i;
  logic       [CHW-1:0] rr_chan_o, chan_done_id_i, desc_wb_chan_o, rr;
  logic       [9:0]     pt [4] = '{10'h000, 10'h240, 10'h2c0, 10'h040};
  uot_irq_t             evt_i, int_mask_i, int_clr_i, int_sts_o;
  uot_req_t             req_i;
  uot_txn_t             txn_o, cur;
  uot_rxsts_t           rx_sts_i, rxsts_o;
  uot_req_t             pq[$], nq[$];
  logic                 attach, hs_cap, ex;
  int                   stp_cnt, err_count, check_count, n;
  // flags the core raises from its own inputs and whose event lines it ignores, h_port (bit 20) among them
  localparam logic [IRQW-1:0] CORE_OWN = 27'h1900900;

  uot_core uot_core_inst (
    .mclk_i, .reset_i, .ulpi_clk_i, .soft_reset_i, .host_mode_i, .ulpi_conn_i,
    .ulpi_hs_i, .ulpi_stp_o, .evt_i, .int_mask_i, .int_clr_i, .int_sts_o,
    .irq_o, .ptx_half_i, .ptx_lvl_i, .iso_out_i, .rx_free_i, .iso_mps_i,
    .reg_acc_i, .reg_grp_i, .fifo_wr_i, .fifo_rd_i, .fifo_addr_i,
    .fifo_wdata_i, .spram_we_o, .spram_re_o, .spram_addr_o, .spram_wdata_o,
    .port_power_i, .port_reset_i, .conn_clr_i, .enchg_clr_i, .vbus_en_o,
    .port_conn_det_o, .port_en_chg_o, .port_enabled_o, .port_speed_o,
    .pq_wr_i, .nq_wr_i, .req_i, .sof_i, .txn_done_i, .txn_valid_o, .txn_o,
    .chan_en_i, .rr_chan_o, .chan_done_i, .chan_done_id_i, .desc_wb_o,
    .desc_wb_chan_o, .rx_pkt_i, .rx_sts_i, .rxsts_vld_o, .rxsts_o
  );

  uot_phy_model uot_phy_model_inst (
    .ulpi_stp_i(ulpi_stp_o), .attach_i(attach), .hs_cap_i(hs_cap),
    .ulpi_clk_o(ulpi_clk_i), .conn_o(ulpi_conn_i), .hs_o(ulpi_hs_i),
    .stp_cnt_o(stp_cnt)
  );

  always #20 mclk_i = ~mclk_i;

  task automatic step(input int k);
    repeat (k) @(negedge mclk_i);
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic bail();
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    final_report();
  endtask : bail

  task automatic clr_all();
    int_clr_i = '1;
    step(1);
    int_clr_i = '0;
  endtask : clr_all

  task automatic push(input logic per);
    req_i.tok  = uot_tok_e'($urandom_range(2, 0));
    req_i.chan = CHW'($urandom);
    if (per) begin
      pq_wr_i = 1'b1;
      pq.push_back(req_i);
    end else begin
      nq_wr_i = 1'b1;
      nq.push_back(req_i);
    end
    step(1);
    {pq_wr_i, nq_wr_i} = 2'b00;
    step(1);
  endtask : push

  function automatic logic [3:0] nxt(input logic [3:0] c,
                                     input logic [7:0] en);
    logic [3:0] k;
    for (int i = 1; i <= 8; i++) begin
      k = 4'((c + i) % 8);
      if (en[k[2:0]]) return k;
    end
    return c;
  endfunction : nxt

  initial begin
    {mclk_i, soft_reset_i, host_mode_i, ptx_half_i, iso_out_i} = '0;
    {reg_acc_i, reg_grp_i, fifo_wr_i, fifo_rd_i, fifo_addr_i} = '0;
    {fifo_wdata_i, port_power_i, port_reset_i, conn_clr_i, enchg_clr_i} = '0;
    {pq_wr_i, nq_wr_i, req_i, sof_i, txn_done_i, chan_en_i} = '0;
    {chan_done_i, chan_done_id_i, rx_pkt_i, rx_sts_i, attach, hs_cap} = '0;
    {evt_i, int_clr_i, rx_free_i, iso_mps_i} = '0;
    {err_count, check_count} = '0;
    int_mask_i = '1;
    ptx_lvl_i  = 9'h100;
    reset_i    = 1'b1;
    void'($urandom(78));
    step(2);
    n = 0;
    while (stp_cnt < 12 && n < 100) begin
      step(1);
      n++;
    end
    if (n == 100) bail();
    check(ulpi_stp_o, 1'b1, "stop in reset");
    check({vbus_en_o, txn_valid_o, int_sts_o, irq_o}, '0,
          "reset state");
    reset_i = 1'b0;
    step(8);
    check(ulpi_stp_o, 1'b0, "stop released");
    for (int m = 0; m < 2; m++) begin
      host_mode_i = m[0];
      for (int b = 0; b < 27; b++) begin
        int_mask_i = uot_irq_t'($urandom);
        evt_i = uot_irq_t'(27'h1 << b);
        step(1);
        evt_i = '0;
        ex = !((m == 1 && DEV_MASK[b]) || (m == 0 && HOST_MASK[b]));
        ex = ex && !CORE_OWN[b];
        check(int_sts_o[b], ex, "flag");
        check(irq_o, ex & int_mask_i[b], "irq");
        clr_all();
        check({int_sts_o[b], irq_o}, 2'b00, "flag cleared");
      end
    end
    int_mask_i = '1;
    for (int i = 0; i < 4; i++) begin
      {ptx_half_i, ptx_lvl_i} = pt[i];
      clr_all();
      step(2);
      check(int_sts_o[23], i < 2, "ptx empty");
    end
    {ptx_half_i, ptx_lvl_i} = 10'h100;
    clr_all();
    for (int i = 0; i < 6; i++) begin
      host_mode_i = i[0];
      reg_grp_i   = 2'(i / 2);
      reg_acc_i   = 1'b1;
      step(1);
      reg_acc_i   = 1'b0;
      ex = (i[0] && reg_grp_i == GRP_DEV) || (!i[0] && reg_grp_i == GRP_HOST);
      check(int_sts_o[8], ex, "mode mismatch");
      clr_all();
    end
    host_mode_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      iso_mps_i = 13'($urandom_range(1023, 64));
      rx_free_i = iso_mps_i - 13'(1 - i);
      iso_out_i = 1'b1;
      step(1);
      iso_out_i = 1'b0;
      check(int_sts_o[11], i == 0, "iso drop");
      clr_all();
    end
    for (int i = 0; i < 16; i++) begin
      {fifo_wr_i, fifo_rd_i} = 2'($urandom_range(2, 1));
      fifo_addr_i  = {1'b0, ($urandom_range(1) != 0), 13'($urandom), 2'b00};
      fifo_wdata_i = $urandom;
      step(1);
      ex = fifo_wr_i && fifo_addr_i < SPRAM_LIM;
      check({spram_we_o, spram_re_o}, {ex, fifo_rd_i},
            "fifo strobe");
      if (ex) check({spram_addr_o, spram_wdata_o},
                    {fifo_addr_i[14:2], fifo_wdata_i}, "fifo word");
    end
    {fifo_wr_i, fifo_rd_i} = 2'b00;
    host_mode_i  = 1'b1;
    port_power_i = 1'b1;
    step(1);
    check(vbus_en_o, 1'b1, "bus supply");
    for (int h = 0; h < 2; h++) begin
      hs_cap = h[0];
      attach = 1'b1;
      n = 0;
      while (port_conn_det_o !== 1'b1 && n < 50) begin
        step(1);
        n++;
      end
      if (n == 50) bail();
      step(1);
      check(int_sts_o[20], 1'b1, "port flag");
      port_reset_i = 1'b1;
      step(4);
      port_reset_i = 1'b0;
      step(1);
      check({port_en_chg_o, port_enabled_o, port_speed_o},
            {2'b11, h ? SPD_HS : SPD_FS}, "port enable");
      attach = 1'b0;
      n = 0;
      while (port_enabled_o !== 1'b0 && n < 50) begin
        step(1);
        n++;
      end
      if (n == 50) bail();
      step(1);
      check(int_sts_o[24], 1'b1, "disconnect");
      {conn_clr_i, enchg_clr_i} = 2'b11;
      clr_all();
      {conn_clr_i, enchg_clr_i} = 2'b00;
      check({port_conn_det_o, port_en_chg_o}, 2'b00, "port clear");
    end
    chan_en_i = 8'h20;
    push(1'b0);
    cur = {1'b0, nq.pop_front()};
    push(1'b0);
    push(1'b1);
    push(1'b1);
    sof_i = 1'b1;
    step(1);
    sof_i = 1'b0;
    rr = 4'h5;
    repeat (4) begin
      check(txn_valid_o, 1'b1, "txn valid");
      check(txn_o, cur, "txn order");
      txn_done_i = 1'b1;
      step(1);
      txn_done_i = 1'b0;
      check(rr_chan_o, rr, "rr chan");
      chan_en_i = 8'($urandom) | 8'h01;
      rr = nxt(rr, chan_en_i);
      if (pq.size() > 0) cur = {1'b1, pq.pop_front()};
      else if (nq.size() > 0) cur = {1'b0, nq.pop_front()};
      else break;
      n = 0;
      while (txn_valid_o !== 1'b1 && n < 20) begin
        step(1);
        n++;
      end
      if (n == 20) bail();
    end
    repeat (4) begin
      {chan_done_i, rx_pkt_i} = 2'b11;
      chan_done_id_i = CHW'($urandom);
      rx_sts_i = uot_rxsts_t'($urandom);
      step(1);
      {chan_done_i, rx_pkt_i} = 2'b00;
      check({desc_wb_o, desc_wb_chan_o}, {1'b1, chan_done_id_i},
            "wb");
      check({rxsts_vld_o, rxsts_o}, {1'b1, rx_sts_i}, "rx status");
      step(1);
      check({desc_wb_o, rxsts_vld_o}, 2'b00, "one pulse");
    end
    evt_i = HOST_MASK;
    step(1);
    evt_i = '0;
    soft_reset_i = 1'b1;
    step(1);
    check({int_sts_o, vbus_en_o, txn_valid_o}, '0, "soft reset");
    step(8);
    check(ulpi_stp_o, 1'b1, "soft stop");
    soft_reset_i = 1'b0;
    step(4);
    final_report();
  end
endmodule : testbench
